// *** owpm_defines.svh ***
// Constants for the oscillator monitor and power mode sequencer.
// Assumes a 100 MHz APB clock and an 8-bit power control register.
`ifndef OWPM_DEFINES_SVH
`define OWPM_DEFINES_SVH
// Register byte addresses
`define OWPM_POWER_CONTROL_REG_ADDR 12'h000
`define OWPM_STAT_ADDR 12'h004
// Power control register bit positions
`define OWPM_B_IDLE_EN 0
`define OWPM_B_PD_EN 1
`define OWPM_B_SLOW 4
`define OWPM_B_IDLE_SET 5
`define OWPM_B_PD_SET 6
`define OWPM_POWER_CONTROL_REG_RST 8'h00
// Timing
`define OWPM_CLK_MHZ 100
`define OWPM_STAB_US 1000
`define OWPM_STAB_CYC (`OWPM_STAB_US * `OWPM_CLK_MHZ)
`define OWPM_HWRST_CYC 16
`define OWPM_SLOW_DIV 8
`define OWPM_RC_WIN 8
`endif

// *** owpm_pkg.sv ***
// Types for the oscillator monitor and power mode sequencer.
// Assumes owpm_defines.svh supplies all numeric constants.
package owpm_pkg;
  // Power and reset sequencing states
  typedef enum logic [2:0] {
    ST_POR, ST_STAB, ST_RUN, ST_IDLE, ST_SWPD, ST_WAKE, ST_HWRST, ST_HW_POWERDOWN_N
  } owpm_state_t;
  // Clock enables and source select handed to the clock tree
  typedef struct packed {
    logic cpu_en;
    logic per_en;
    logic rc_sel;
  } owpm_clk_t;
  // Oscillator and pad controls
  typedef struct packed {
    logic main_osc_en;
    logic rc_osc_en;
    logic ports_hiz;
  } owpm_pwr_t;
endpackage

// *** owpm_top.sv ***
// Oscillator monitor with power mode sequencer, APB register slave.
// Assumes oscillator ticks and pins are asynchronous; the rest is pclk.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`include "owpm_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module owpm_top import owpm_pkg::*; #(
  parameter int STAB_CYC = `OWPM_STAB_CYC,
  parameter int HWRST_CYC = `OWPM_HWRST_CYC,
  parameter int RC_WIN = `OWPM_RC_WIN
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic main_osc_tick,
  input wire logic rc_osc_tick,
  input wire logic hw_powerdown_n,
  input wire logic wake_interrupt_pin,
  input wire logic periph_irq,
  output owpm_clk_t clk_ctl,
  output owpm_pwr_t pwr_ctl,
  output logic sys_rst_n
);

  localparam int SW = $clog2(STAB_CYC + 1);
  localparam int HW = $clog2(HWRST_CYC + 1);

  // Pin synchronisers: 0 hw_powerdown_n_n, 1 wake, 2 main tick, 3 rc tick
  logic [3:0] pin_in;
  logic [3:0] filt_ff;
  logic [3:0] filt_q_ff;
  assign pin_in = {rc_osc_tick, main_osc_tick, wake_interrupt_pin,
                   hw_powerdown_n};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      // Pins idle high, oscillator ticks idle low
      localparam logic IDLE_LVL = (gi < 2) ? 1'b1 : 1'b0;
      logic [2:0] sync_ff;
      // Three stages; a change counts once stages two and three agree
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_ff <= {3{IDLE_LVL}};
          filt_ff[gi] <= IDLE_LVL;
          filt_q_ff[gi] <= IDLE_LVL;
        end else begin
          sync_ff <= {sync_ff[1:0], pin_in[gi]};
          if (sync_ff[1] == sync_ff[2]) begin
            filt_ff[gi] <= sync_ff[2];
          end
          filt_q_ff[gi] <= filt_ff[gi];
        end
      end
    end
  endgenerate

  logic hw_powerdown_n_n_s;
  logic hw_powerdown_n_fell;
  logic wake_fell;
  logic main_rise;
  logic rc_rise;
  assign hw_powerdown_n_n_s = filt_ff[0];
  assign hw_powerdown_n_fell = filt_q_ff[0] & ~filt_ff[0];
  // A low pulse is seen on its falling edge
  assign wake_fell = filt_q_ff[1] & ~filt_ff[1];
  assign main_rise = filt_ff[2] & ~filt_q_ff[2];
  assign rc_rise = filt_ff[3] & ~filt_q_ff[3];

  owpm_state_t state_ff;
  owpm_state_t nxt_state;
  logic osc_good_ff;
  logic [7:0] win_cnt_ff;
  logic [7:0] main_cnt_ff;
  logic [SW-1:0] stab_cnt_ff;
  logic [HW-1:0] hwrst_cnt_ff;
  logic [2:0] div_ff;
  logic [7:0] power_control_reg_ff; // Power control register image
  logic arm_idle_ff; // Idle enable from the previous transfer
  logic arm_pd_ff; // Power-down enable from the previous transfer
  logic monitor_on;
  logic stab_done;
  logic hwrst_done;

  // Monitor only while the main oscillator is supposed to run
  assign monitor_on = pwr_ctl.main_osc_en;
  assign stab_done = (stab_cnt_ff == SW'(STAB_CYC - 1));
  assign hwrst_done = (hwrst_cnt_ff == HW'(HWRST_CYC - 1));

  // Frequency compare: count main edges over RC_WIN RC edges.
  // Fewer main edges than RC edges means the main clock is slower.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_ff <= 8'h00;
      main_cnt_ff <= 8'h00;
      osc_good_ff <= 1'b0;
    end else if (!monitor_on) begin
      win_cnt_ff <= 8'h00;
      main_cnt_ff <= 8'h00;
      osc_good_ff <= 1'b0;
    end else if (rc_rise && win_cnt_ff == 8'(RC_WIN - 1)) begin
      win_cnt_ff <= 8'h00;
      main_cnt_ff <= 8'h00;
      osc_good_ff <= (main_cnt_ff >= 8'(RC_WIN));
    end else begin
      if (rc_rise) begin
        win_cnt_ff <= win_cnt_ff + 8'h01;
      end
      // Saturate so a fast crystal cannot wrap to a false failure
      if (main_rise && main_cnt_ff != 8'hff) begin
        main_cnt_ff <= main_cnt_ff + 8'h01;
      end
    end
  end

  // APB decode; zero wait states, so every access completes at once
  logic apb_done;
  logic apb_wr;
  logic power_control_reg_wr;
  logic hit;
  logic idle_go;
  logic pd_go;
  assign apb_done = psel & penable;
  assign apb_wr = apb_done & pwrite;
  assign hit = (paddr == `OWPM_POWER_CONTROL_REG_ADDR) | (paddr == `OWPM_STAT_ADDR);
  assign power_control_reg_wr = apb_wr & (paddr == `OWPM_POWER_CONTROL_REG_ADDR);
  assign pready = 1'b1;
  assign pslverr = apb_done & ~hit;
  // Set write only counts right after its enable write
  assign idle_go = power_control_reg_wr & pwdata[`OWPM_B_IDLE_SET] & arm_idle_ff;
  assign pd_go = power_control_reg_wr & pwdata[`OWPM_B_PD_SET] & arm_pd_ff
                 & ~idle_go;

  // Sequencer next state; the power-down pin overrides everything
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_POR: begin
        if (osc_good_ff) begin
          nxt_state = ST_STAB;
        end
      end
      ST_STAB: begin
        if (!osc_good_ff) begin
          nxt_state = ST_POR;
        end else if (stab_done) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!osc_good_ff) begin
          nxt_state = ST_POR;
        end else if (idle_go) begin
          nxt_state = ST_IDLE;
        end else if (pd_go) begin
          nxt_state = ST_SWPD;
        end
      end
      ST_IDLE: begin
        if (!osc_good_ff) begin
          nxt_state = ST_POR;
        end else if (periph_irq) begin
          nxt_state = ST_RUN;
        end
      end
      ST_SWPD: begin
        if (wake_fell) begin
          nxt_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // Oscillator restarts; program resumes without reset
        if (osc_good_ff && stab_done) begin
          nxt_state = ST_RUN;
        end
      end
      ST_HWRST: begin
        if (hwrst_done) begin
          nxt_state = ST_HW_POWERDOWN_N;
        end
      end
      ST_HW_POWERDOWN_N: begin
        if (hw_powerdown_n_n_s) begin
          nxt_state = ST_POR;
        end
      end
      default: nxt_state = ST_POR;
    endcase
    if (!hw_powerdown_n_n_s && state_ff != ST_HWRST && state_ff != ST_HW_POWERDOWN_N) begin
      nxt_state = ST_HWRST;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_POR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Stabilisation timer; counts in STAB and WAKE while the oscillator looks good, else holds; clears in other states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_cnt_ff <= '0;
    end else if ((state_ff == ST_STAB || state_ff == ST_WAKE)
                 && osc_good_ff && !stab_done) begin
      stab_cnt_ff <= stab_cnt_ff + SW'(1);
    end else if (state_ff != ST_STAB && state_ff != ST_WAKE) begin
      stab_cnt_ff <= '0;
    end
  end

  // Internal reset sequence length before hardware power-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hwrst_cnt_ff <= '0;
    end else if (state_ff == ST_HWRST && !hwrst_done) begin
      hwrst_cnt_ff <= hwrst_cnt_ff + HW'(1);
    end else if (state_ff != ST_HWRST) begin
      hwrst_cnt_ff <= '0;
    end
  end

  // Power control register. Enables last one transfer only, so a
  // stray set write far from its enable cannot stop the clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_control_reg_ff <= `OWPM_POWER_CONTROL_REG_RST;
      arm_idle_ff <= 1'b0;
      arm_pd_ff <= 1'b0;
    end else if (!sys_rst_n) begin
      power_control_reg_ff <= `OWPM_POWER_CONTROL_REG_RST; // Internal reset also restores rate
      arm_idle_ff <= 1'b0;
      arm_pd_ff <= 1'b0;
    end else begin
      if (apb_done) begin
        // Any transfer consumes the enables
        arm_idle_ff <= power_control_reg_wr & pwdata[`OWPM_B_IDLE_EN]
                       & ~pwdata[`OWPM_B_IDLE_SET];
        arm_pd_ff <= power_control_reg_wr & pwdata[`OWPM_B_PD_EN]
                     & ~pwdata[`OWPM_B_PD_SET];
      end
      if (power_control_reg_wr && state_ff == ST_RUN) begin
        power_control_reg_ff[`OWPM_B_SLOW] <= pwdata[`OWPM_B_SLOW];
        power_control_reg_ff[`OWPM_B_IDLE_EN] <= pwdata[`OWPM_B_IDLE_EN];
        power_control_reg_ff[`OWPM_B_PD_EN] <= pwdata[`OWPM_B_PD_EN];
        power_control_reg_ff[`OWPM_B_IDLE_SET] <= idle_go;
        power_control_reg_ff[`OWPM_B_PD_SET] <= pd_go;
      end else if (state_ff == ST_RUN) begin
        // Mode bits drop once the mode has been left
        power_control_reg_ff[`OWPM_B_IDLE_SET] <= 1'b0;
        power_control_reg_ff[`OWPM_B_PD_SET] <= 1'b0;
      end
    end
  end

  // Slow-down divider; free running, pulse at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 3'h0;
    end else begin
      div_ff <= div_ff + 3'h1;
    end
  end

  logic slow_tick;
  logic in_run;
  assign in_run = (state_ff == ST_RUN) | (state_ff == ST_WAKE);
  // One pulse in eight while slow-down is on
  assign slow_tick = power_control_reg_ff[`OWPM_B_SLOW] ? (div_ff == 3'h0) : 1'b1;

  // Clock and pad controls
  always_comb begin
    clk_ctl.cpu_en = (state_ff == ST_RUN) & slow_tick;
    clk_ctl.per_en = ((state_ff == ST_RUN) | (state_ff == ST_IDLE))
                     & slow_tick;
    // Power-on reset always runs from RC; the crystal takes over in STAB
    clk_ctl.rc_sel = ~osc_good_ff | (state_ff == ST_POR);
    pwr_ctl.main_osc_en = (state_ff != ST_SWPD)
                          & (state_ff != ST_HW_POWERDOWN_N);
    pwr_ctl.rc_osc_en = (state_ff != ST_HW_POWERDOWN_N);
    pwr_ctl.ports_hiz = (state_ff == ST_HW_POWERDOWN_N);
    sys_rst_n = ~((state_ff == ST_POR) | (state_ff == ST_STAB)
                  | (state_ff == ST_HWRST) | (state_ff == ST_HW_POWERDOWN_N));
  end

  // Read data captured in the setup phase, so it is a flop output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `OWPM_POWER_CONTROL_REG_ADDR) begin
        prdata <= {24'h00_0000, power_control_reg_ff};
      end else if (paddr == `OWPM_STAT_ADDR) begin
        prdata <= {27'h0, in_run, ~osc_good_ff, state_ff};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_fail_rst;
    state_ff == ST_RUN && !osc_good_ff && hw_powerdown_n_n_s
      |=> state_ff == ST_POR ##0 !sys_rst_n;
  endproperty
  a_fail_rst: assert property (p_fail_rst)
    else $error("failure did not force reset");

  property p_por_rc;
    state_ff == ST_POR |-> !sys_rst_n && clk_ctl.rc_sel;
  endproperty
  a_por_rc: assert property (p_por_rc)
    else $error("power-on reset not on RC clock");

  property p_stab;
    $rose(state_ff == ST_STAB) |-> !sys_rst_n [*8];
  endproperty
  a_stab: assert property (p_stab)
    else $error("reset released during stabilisation");

  property p_stab_end;
    state_ff == ST_STAB && osc_good_ff && stab_done && hw_powerdown_n_n_s
      |=> state_ff == ST_RUN && sys_rst_n;
  endproperty
  a_stab_end: assert property (p_stab_end)
    else $error("stabilisation end did not release");

  property p_idle_clk;
    state_ff == ST_IDLE |-> !clk_ctl.cpu_en
      && clk_ctl.per_en == slow_tick;
  endproperty
  a_idle_clk: assert property (p_idle_clk)
    else $error("idle clock gating wrong");

  property p_idle_exit;
    state_ff == ST_IDLE && periph_irq && osc_good_ff && hw_powerdown_n_n_s
      |=> state_ff == ST_RUN;
  endproperty
  a_idle_exit: assert property (p_idle_exit)
    else $error("interrupt did not end idle");

  property p_slow;
    state_ff == ST_RUN && power_control_reg_ff[`OWPM_B_SLOW]
      |-> clk_ctl.cpu_en == (div_ff == 3'h0);
  endproperty
  a_slow: assert property (p_slow)
    else $error("slow-down enable not one in eight");

  property p_swpd;
    state_ff == ST_SWPD |-> !pwr_ctl.main_osc_en
      && !clk_ctl.cpu_en && !clk_ctl.per_en;
  endproperty
  a_swpd: assert property (p_swpd)
    else $error("software power-down still running");

  property p_wake;
    state_ff == ST_SWPD && wake_fell && hw_powerdown_n_n_s
      |=> state_ff == ST_WAKE;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake pulse ignored");

  property p_hw_powerdown_n_in;
    hw_powerdown_n_fell |=> state_ff == ST_HWRST ##1 !sys_rst_n;
  endproperty
  a_hw_powerdown_n_in: assert property (p_hw_powerdown_n_in)
    else $error("power-down pin did not start reset");

  property p_hw_powerdown_n_off;
    state_ff == ST_HW_POWERDOWN_N |-> !pwr_ctl.main_osc_en
      && !pwr_ctl.rc_osc_en && pwr_ctl.ports_hiz;
  endproperty
  a_hw_powerdown_n_off: assert property (p_hw_powerdown_n_off)
    else $error("hardware power-down left clocks on");

  property p_hw_powerdown_n_out;
    state_ff == ST_HW_POWERDOWN_N && hw_powerdown_n_n_s |=> state_ff == ST_POR;
  endproperty
  a_hw_powerdown_n_out: assert property (p_hw_powerdown_n_out)
    else $error("pin release did not restart");

  property p_seq;
    state_ff == ST_RUN && osc_good_ff && hw_powerdown_n_n_s && power_control_reg_wr
      && !arm_idle_ff && !arm_pd_ff |=> state_ff != ST_IDLE
      && state_ff != ST_SWPD;
  endproperty
  a_seq: assert property (p_seq)
    else $error("mode entered without enable write");

  property p_slow_wr;
    state_ff == ST_RUN && sys_rst_n && power_control_reg_wr
      |=> power_control_reg_ff[`OWPM_B_SLOW] == $past(pwdata[`OWPM_B_SLOW]);
  endproperty
  a_slow_wr: assert property (p_slow_wr)
    else $error("slow-down bit not written");

  c_idle: cover property (state_ff == ST_RUN ##1 state_ff == ST_IDLE);
  c_wake: cover property (state_ff == ST_SWPD ##1 state_ff == ST_WAKE);
  c_hw_powerdown_n: cover property (state_ff == ST_HW_POWERDOWN_N ##1 state_ff == ST_POR);

endmodule
`default_nettype wire

// *** owpm_partner.sv ***
// Behavioural model of the main crystal and the auxiliary RC oscillator.
// Assumes pwr_ctl comes from the sequencer; osc_fail stalls the crystal.
`timescale 1ns/1ns
`default_nettype none
module owpm_partner import owpm_pkg::*; (
  input wire owpm_pwr_t pwr_ctl,
  input wire logic osc_fail,
  output logic main_osc_tick,
  output logic rc_osc_tick
);
  // Tick levels; both stand still while their oscillator is off
  logic main_q = 1'b0;
  logic rc_q = 1'b0;

  assign main_osc_tick = main_q;
  assign rc_osc_tick = rc_q;

  // Crystal runs four times the RC rate; both toggle only at falling pclk
  // edges, so the sampling edge never races them. A staged failure
  // freezes the crystal so the monitor sees no edges at all.
  always begin
    #20;
    if (pwr_ctl.main_osc_en === 1'b1 && osc_fail !== 1'b1) begin
      main_q = ~main_q;
    end
  end

  // RC oscillator, the reference for the frequency comparison
  always begin
    #80;
    if (pwr_ctl.rc_osc_en === 1'b1) begin
      rc_q = ~rc_q;
    end
  end
endmodule
`default_nettype wire

// *** test_osc_monitor_power_modes.sv ***
// Self-checking bench for the oscillator monitor and power sequencer.
// Assumes owpm_pkg, owpm_top and owpm_partner are compiled before it.
`include "owpm_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module test_osc_monitor_power_modes import owpm_pkg::*;;
  // Short stabilisation keeps the run brief; expectations derive from it
  localparam int STAB = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, main_tick, rc_tick, sys_rst_n;
  logic hw_powerdown_n_n = 1'b1;
  logic wake = 1'b1;
  logic irq = 1'b0;
  logic osc_fail = 1'b0;
  owpm_clk_t clk_ctl;
  owpm_pwr_t pwr_ctl;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int last_rst = 0;
  logic [31:0] rd;
  logic err;
  logic [31:0] c_cpu, c_per;

  always #5 pclk = ~pclk;

  owpm_top #(.STAB_CYC(STAB), .HWRST_CYC(16), .RC_WIN(8)) u_owpm_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .main_osc_tick(main_tick),
    .rc_osc_tick(rc_tick), .hw_powerdown_n(hw_powerdown_n_n),
    .wake_interrupt_pin(wake), .periph_irq(irq), .clk_ctl(clk_ctl),
    .pwr_ctl(pwr_ctl), .sys_rst_n(sys_rst_n));

  owpm_partner u_owpm_partner (.pwr_ctl(pwr_ctl), .osc_fail(osc_fail),
    .main_osc_tick(main_tick), .rc_osc_tick(rc_tick));

  // Cycle stamp of the latest internal reset, to prove a wake kept state
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (sys_rst_n !== 1'b1) begin
      last_rst <= cyc;
    end
  end

  // Single comparison point; unknowns never match
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Polls the status register until the state shows, bounded by lim
  task automatic wait_state(input logic [2:0] st, input int lim);
    int n;
    n = 0;
    do begin
      apb(1'b0, `OWPM_STAT_ADDR, 32'h0);
      n++;
    end while (rd[2:0] !== st && n < lim);
    chk("state", {29'h0, st}, {29'h0, rd[2:0]});
  endtask

  // Counts CPU and peripheral clock enables over 64 cycles
  task automatic count_en;
    c_cpu = 32'h0;
    c_per = 32'h0;
    repeat (64) begin
      @(posedge pclk);
      c_cpu = c_cpu + clk_ctl.cpu_en;
      c_per = c_per + clk_ctl.per_en;
    end
  endtask

  // Idle entry, optionally with slow-down, and exit by interrupt
  task automatic t_idle(input logic slow);
    apb(1'b1, `OWPM_POWER_CONTROL_REG_ADDR, 32'h01);
    apb(1'b1, `OWPM_POWER_CONTROL_REG_ADDR, slow ? 32'h31 : 32'h21);
    wait_state(3'd3, 4);
    count_en();
    chk("idle cpu", 32'd0, c_cpu);
    chk("idle per", slow ? 32'd8 : 32'd64, c_per);
    irq <= 1'b1;
    wait_state(3'd2, 10);
    irq <= 1'b0;
    apb(1'b1, `OWPM_POWER_CONTROL_REG_ADDR, 32'h0);
  endtask

  // Set writes without the enable just before must be ignored
  task automatic t_refuse;
    apb(1'b1, `OWPM_POWER_CONTROL_REG_ADDR, 32'h20);
    wait_state(3'd2, 1);
    apb(1'b1, `OWPM_POWER_CONTROL_REG_ADDR, 32'h02);
    apb(1'b1, `OWPM_POWER_CONTROL_REG_ADDR, 32'h00);
    apb(1'b1, `OWPM_POWER_CONTROL_REG_ADDR, 32'h40);
    wait_state(3'd2, 1);
  endtask

  // Software power-down and wake by a short low pulse, without reset
  task automatic t_swpd;
    int mark;
    apb(1'b1, `OWPM_POWER_CONTROL_REG_ADDR, 32'h02);
    apb(1'b1, `OWPM_POWER_CONTROL_REG_ADDR, 32'h42);
    wait_state(3'd4, 4);
    count_en();
    chk("pd main osc", 32'd0, {31'h0, pwr_ctl.main_osc_en});
    chk("pd cpu", 32'd0, c_cpu);
    mark = cyc;
    wake <= 1'b0;
    repeat (6) @(posedge pclk);
    wake <= 1'b1;
    wait_state(3'd2, 200);
    chk("no reset on wake", 32'd1, {31'h0, last_rst < mark});
  endtask

  // Crystal failure: RC clock and reset, then held for stabilisation
  task automatic t_fail;
    int n;
    int ns;
    osc_fail <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sys_rst_n !== 1'b0 && n < 500);
    @(posedge pclk);
    chk("fail rst", 32'd0, {31'h0, sys_rst_n});
    chk("fail rc_sel", 32'd1, {31'h0, clk_ctl.rc_sel});
    osc_fail <= 1'b0;
    n = 0;
    ns = 0;
    // Cycles on the crystal clock while reset still holds
    do begin
      @(posedge pclk);
      n++;
      if (sys_rst_n === 1'b0 && clk_ctl.rc_sel === 1'b0) ns++;
    end while (sys_rst_n !== 1'b1 && n < 2000);
    chk("stab held", 32'd1, {31'h0, n > STAB});
    chk("stab length", 32'(STAB), ns);
    wait_state(3'd2, 5);
  endtask

  // Hardware power-down with slow-down set beforehand
  task automatic t_hw_powerdown_n;
    apb(1'b1, `OWPM_POWER_CONTROL_REG_ADDR, 32'h10);
    hw_powerdown_n_n <= 1'b0;
    wait_state(3'd6, 20);
    chk("hw rst", 32'd0, {31'h0, sys_rst_n});
    wait_state(3'd7, 20);
    chk("hw_powerdown_n pwr", 32'd1, {29'h0, pwr_ctl});
    hw_powerdown_n_n <= 1'b1;
    wait_state(3'd2, 500);
    chk("hw exit rst", 32'd1, {31'h0, sys_rst_n});
    count_en();
    chk("slow cleared", 32'd64, c_cpu);
  endtask

  // Hardware reset ends software power-down and clears slow-down
  task automatic t_reset;
    apb(1'b1, `OWPM_POWER_CONTROL_REG_ADDR, 32'h12);
    apb(1'b1, `OWPM_POWER_CONTROL_REG_ADDR, 32'h52);
    wait_state(3'd4, 4);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("rst exit", 32'd0, {31'h0, sys_rst_n});
    chk("rst rc_sel", 32'd1, {31'h0, clk_ctl.rc_sel});
    wait_state(3'd2, 300);
    apb(1'b0, `OWPM_POWER_CONTROL_REG_ADDR, 32'h0);
    chk("rst power_control_reg", 32'h0, rd);
  endtask

  // Prints the counts and the verdict, then ends the run
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Watchdog sized well past the expected run length
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    finish_test();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk("por rst", 32'd0, {31'h0, sys_rst_n});
    chk("por rc_sel", 32'd1, {31'h0, clk_ctl.rc_sel});
    chk("por pwr", 32'd6, {29'h0, pwr_ctl});
    wait_state(3'd2, 300);
    chk("run rc_sel", 32'd0, {31'h0, clk_ctl.rc_sel});
    chk("mapped err", 32'd0, {31'h0, err});
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", 32'd1, {31'h0, err});
    chk("unmapped data", 32'd0, rd);
    apb(1'b1, `OWPM_POWER_CONTROL_REG_ADDR, 32'h10);
    apb(1'b0, `OWPM_POWER_CONTROL_REG_ADDR, 32'h0);
    chk("power_control_reg read", 32'h10, rd);
    count_en();
    chk("slow cpu", 32'd8, c_cpu);
    chk("slow per", 32'd8, c_per);
    apb(1'b1, `OWPM_POWER_CONTROL_REG_ADDR, 32'h10 & 32'hef);
    count_en();
    chk("full cpu", 32'd64, c_cpu);
    t_refuse();
    t_idle(1'b0);
    t_idle(1'b1);
    t_swpd();
    t_fail();
    t_hw_powerdown_n();
    t_reset();
    finish_test();
  end
endmodule
`default_nettype wire
